// File: hw/scpr_pkg.sv
// shared constants and state types for the serial config memory read side
// assumes one 100 MHz system clock; loader pins arrive asynchronously
package scpr_pkg;
   localparam int          CAPACITY   = 65536;
   localparam int          ADDR_W     = 17;
   localparam int          MEM_AW     = 16;
   localparam logic [16:0] TERMINAL   = 17'h0_ffff;
   localparam logic [16:0] PAST_TERM  = 17'h1_0000;
   localparam logic [16:0] ADDR_ZERO  = 17'h0_0000;
   localparam logic [16:0] ADDR_ONE   = 17'h0_0001;
   localparam int          FIFO_DEPTH = 4;
   localparam int          FIFO_W     = 1;

   // state of the read side, apart from the prefetch fifo and the bit store
   typedef struct packed {
      logic              clk_meta;
      logic              clk_sync;
      logic              clk_prev;
      logic              ce_meta;
      logic              ce_sync;
      logic              oe_meta;
      logic              oe_sync;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] fetch_addr;
      logic              primed;
      logic              data;
      logic              data_oe;
      logic              cso_n;
      logic              standby;
   } scpr_state_s;

   localparam scpr_state_s STATE_RESET = '{clk_meta: 1'b0, clk_sync: 1'b0,
      clk_prev: 1'b0, ce_meta: 1'b1, ce_sync: 1'b1, oe_meta: 1'b0,
      oe_sync: 1'b0, addr: ADDR_ZERO, fetch_addr: ADDR_ZERO, primed: 1'b0,
      data: 1'b0, data_oe: 1'b0, cso_n: 1'b1, standby: 1'b1};
endpackage

// File: hw/scpr_top.sv
// serial config memory read side: bit store, prefetch fifo, address counter
// assumes loader pins are asynchronous and toggle slower than 1/8 of clock
`timescale 1ns/1ps

// small first-in first-out buffer with valid/ready on both sides
module scpr_fifo
#(
   parameter int W = 1,
   parameter int D = 4
)
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } scpr_fifo_s;

   scpr_fifo_s     st_reg;
   scpr_fifo_s     st_next;
   logic [W-1:0]   mem [D];
   logic           push;
   logic           pop;

   // handshakes against honest full and empty
   assign in_ready  = (st_reg.count != CW'(D));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = mem[st_reg.rd_ptr];
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   // pointer and count update
   always_comb
   begin
      st_next = st_reg;
      if (flush)
      begin
         st_next = '0;
      end
      else
      begin
         if (push)
            st_next.wr_ptr = PW'(st_reg.wr_ptr + 1'b1);
         if (pop)
            st_next.rd_ptr = PW'(st_reg.rd_ptr + 1'b1);
         st_next.count = CW'(st_reg.count + CW'(push) - CW'(pop));
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // storage write
   always_ff @(posedge clock)
   begin
      if (push)
         mem[st_reg.wr_ptr] <= in_data;
   end
endmodule

// read side of the one-time-programmable serial configuration memory
module scpr_top
#(
   parameter bit RESET_ACTIVE_LOW = 1'b0
)
(
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   input  wire logic                       load_clk,
   input  wire logic                       chip_en_n,
   input  wire logic                       reset_oe,
   input  wire logic                       prog_we,
   input  wire logic [scpr_pkg::MEM_AW-1:0] prog_addr,
   input  wire logic                       prog_bit,
   output logic                            data_o,
   output logic                            data_oe,
   output logic                            cascade_select_out_n,
   output logic                            standby_o
);
   scpr_pkg::scpr_state_s st_reg;
   scpr_pkg::scpr_state_s st_next;
   logic                  store [scpr_pkg::CAPACITY];
   logic                  ce_act;
   logic                  oe_act;
   logic                  qual_edge;
   logic                  past_term;
   logic                  fetch_valid;
   logic                  fetch_ready;
   logic                  buf_valid;
   logic                  buf_ready;
   logic                  buf_bit;

   // pin stages leave reset at the reset level of the chosen polarity
   localparam logic OE_RESET_LVL = !RESET_ACTIVE_LOW;

   // decoded pin levels, read from second synchroniser stage only
   assign ce_act    = !st_reg.ce_sync;
   assign oe_act    = RESET_ACTIVE_LOW ? st_reg.oe_sync : !st_reg.oe_sync;
   assign qual_edge = st_reg.clk_sync && !st_reg.clk_prev && ce_act && oe_act;
   assign past_term = (st_reg.addr == scpr_pkg::PAST_TERM);

   // prefetch stream: pull bits ahead of the loader clock
   assign fetch_valid = (st_reg.fetch_addr <= scpr_pkg::TERMINAL);
   assign buf_ready   = qual_edge || !st_reg.primed;

   scpr_fifo #(.W(scpr_pkg::FIFO_W), .D(scpr_pkg::FIFO_DEPTH)) i_scpr_fifo
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .flush     (!oe_act),
      .in_valid  (fetch_valid),
      .in_ready  (fetch_ready),
      .in_data   (store[st_reg.fetch_addr[scpr_pkg::MEM_AW-1:0]]),
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_bit)
   );

   // next state of synchronisers, counter, data and cascade output
   always_comb
   begin
      st_next          = st_reg;
      st_next.clk_meta = load_clk;
      st_next.clk_sync = st_reg.clk_meta;
      st_next.clk_prev = st_reg.clk_sync;
      st_next.ce_meta  = chip_en_n;
      st_next.ce_sync  = st_reg.ce_meta;
      st_next.oe_meta  = reset_oe;
      st_next.oe_sync  = st_reg.oe_meta;
      if (fetch_valid && fetch_ready)
         st_next.fetch_addr = st_reg.fetch_addr + scpr_pkg::ADDR_ONE;
      if (!oe_act)
      begin
         st_next.addr       = scpr_pkg::ADDR_ZERO;
         st_next.fetch_addr = scpr_pkg::ADDR_ZERO;
         st_next.primed     = 1'b0;
      end
      else
      begin
         if (qual_edge && !past_term)
            st_next.addr = st_reg.addr + scpr_pkg::ADDR_ONE;
         if (buf_ready)
         begin
            st_next.primed = buf_valid;
            if (buf_valid)
               st_next.data = buf_bit;
         end
      end
      st_next.data_oe = ce_act && oe_act;
      st_next.standby = !ce_act;
      // low only when enabled and read out; high again on disable
      st_next.cso_n = !(ce_act && oe_act && past_term);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg         <= scpr_pkg::STATE_RESET;
         st_reg.oe_meta <= OE_RESET_LVL; // no false enable after reset
         st_reg.oe_sync <= OE_RESET_LVL;
      end
      else
         st_reg <= st_next;
   end

   // programming path fills the bit store
   always_ff @(posedge clock)
   begin
      if (prog_we)
         store[prog_addr] <= prog_bit;
   end

   // outputs straight from flip-flops
   assign data_o               = st_reg.data;
   assign data_oe              = st_reg.data_oe;
   assign cascade_select_out_n = st_reg.cso_n;
   assign standby_o            = st_reg.standby;

   // checks
   sequence s_oe_drop;
      oe_act ##1 !oe_act;
   endsequence

   a_data_hiz_idle: assert property (
         @(posedge clock) disable iff (!rst_n)
         (!ce_act || !oe_act) |=> !data_oe)
      else $error("data driven while disabled");
   a_addr_step_one: assert property (
         @(posedge clock) disable iff (!rst_n)
         (qual_edge && !past_term)
         |=> st_reg.addr == $past(st_reg.addr) + scpr_pkg::ADDR_ONE)
      else $error("address did not advance by one");
   a_reset_addr_zero: assert property (
         @(posedge clock) disable iff (!rst_n)
         !oe_act |=> (st_reg.addr == '0) && !data_oe)
      else $error("address not held at zero in reset");
   a_reset_pin_level: assert property (
         @(posedge clock) disable iff (!rst_n)
         (st_reg.oe_sync == OE_RESET_LVL) |=> st_reg.addr == '0)
      else $error("reset polarity not honoured");
   a_standby_freeze: assert property (
         @(posedge clock) disable iff (!rst_n)
         (!ce_act && oe_act) |=> standby_o && !data_oe
            && st_reg.addr == $past(st_reg.addr))
      else $error("standby did not freeze");
   a_cascade_low_cause: assert property (
         @(posedge clock) disable iff (!rst_n)
         $fell(cascade_select_out_n)
         |-> $past(ce_act && oe_act && past_term))
      else $error("cascade low without cause");
   a_cascade_track_ce: assert property (
         @(posedge clock) disable iff (!rst_n)
         (past_term && oe_act) |=> cascade_select_out_n == !$past(ce_act))
      else $error("cascade not following chip enable");
   a_cascade_hold_hi: assert property (
         @(posedge clock) disable iff (!rst_n)
         s_oe_drop |=> cascade_select_out_n [*2])
      else $error("cascade low after disable");
   a_data_present_bit: assert property (
         @(posedge clock) disable iff (!rst_n)
         (qual_edge && buf_valid && oe_act) |=> data_o == $past(buf_bit))
      else $error("bit not presented after edge");
   a_addr_bounded: assert property (
         @(posedge clock) disable iff (!rst_n)
         st_reg.addr <= scpr_pkg::PAST_TERM)
      else $error("address ran past terminal");
endmodule

// File: bench/scpr_loader.sv
// loader model: drives memory clock, chip enable and reset/enable pins
// assumes tasks are called from a process clocked by clock
`timescale 1ns/1ps

module scpr_loader
(
   input  wire logic clock,
   output logic      load_clk,
   output logic      chip_en_n,
   output logic      reset_oe
);
   // idle: clock low, chip off, memory held in reset (active low pin)
   initial
   begin
      load_clk  = 1'b0;
      chip_en_n = 1'b1;
      reset_oe  = 1'b0;
   end

   // only the clocks asked for; one shared clock for any chained part
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge clock);
         load_clk <= 1'b1;
         repeat (4) @(posedge clock);
         load_clk <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask

   // set enables, then leave time for sync and prefetch
   task automatic set_pins(input logic ce_n, input logic oe_lvl);
      @(posedge clock);
      chip_en_n <= ce_n;
      reset_oe  <= oe_lvl;
      repeat (12) @(posedge clock);
   endtask
endmodule

// File: bench/scpr_top_tb.sv
// self-checking bench for the serial config memory read side
// assumes one part per reset polarity option and bits 0..7 programmed
`timescale 1ns/1ps

module scpr_top_tb;
   logic                        clock;
   logic                        rst_n;
   logic                        load_clk;
   logic                        chip_en_n;
   logic                        reset_oe;
   logic                        prog_we;
   logic [scpr_pkg::MEM_AW-1:0] prog_addr;
   logic                        prog_bit;
   logic                        data_o;
   logic                        data_oe;
   logic                        cascade_select_out_n;
   logic                        standby_o;
   logic                        reset_oe_hi;
   logic                        data_o_hi;
   logic                        data_oe_hi;
   logic                        cascade_hi_n;
   logic                        standby_hi;
   logic                        din_pin;
   logic                        din_pin_hi;
   int                          error_cnt = 0;
   int                          samples_checked = 0;
   logic [7:0]                  pattern = 8'h55; // alternating: any slip shows

   // design with the preferred active low reset option
   scpr_top #(.RESET_ACTIVE_LOW(1'b1)) i_scpr_top (
      .clock(clock), .rst_n(rst_n), .load_clk(load_clk),
      .chip_en_n(chip_en_n), .reset_oe(reset_oe), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_bit(prog_bit), .data_o(data_o),
      .data_oe(data_oe), .cascade_select_out_n(cascade_select_out_n),
      .standby_o(standby_o));

   scpr_loader i_scpr_loader (.clock(clock), .load_clk(load_clk),
      .chip_en_n(chip_en_n), .reset_oe(reset_oe));

   // second part with the default active high reset option, shared clock
   scpr_top #(.RESET_ACTIVE_LOW(1'b0)) i_scpr_top_hi (
      .clock(clock), .rst_n(rst_n), .load_clk(load_clk),
      .chip_en_n(chip_en_n), .reset_oe(reset_oe_hi), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_bit(prog_bit), .data_o(data_o_hi),
      .data_oe(data_oe_hi), .cascade_select_out_n(cascade_hi_n),
      .standby_o(standby_hi));

   // inverted reset level for the second part, so both are in reset together; loader data input pulled up
   assign reset_oe_hi = !reset_oe;
   assign din_pin     = data_oe ? data_o : 1'b1;
   assign din_pin_hi  = data_oe_hi ? data_o_hi : 1'b1;

   // clock generator
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic exp, input logic seen);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic summarize;
      if (error_cnt == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // held in reset: clocks ignored, pin floats, cascade high
   task automatic s_idle;
      i_scpr_loader.pulse(2);
      check("data_oe", 1'b0, data_oe);
      check("data_oe_hi", 1'b0, data_oe_hi);
      check("standby", 1'b1, standby_o);
      check("standby_hi", 1'b1, standby_hi);
      check("cascade", 1'b1, cascade_select_out_n);
   endtask

   // readout from address zero, one bit per qualified clock
   task automatic s_read;
      i_scpr_loader.set_pins(1'b0, 1'b1);
      check("data_oe", 1'b1, data_oe);
      check("data_oe_hi", 1'b1, data_oe_hi);
      check("standby", 1'b0, standby_o);
      check("bit0", pattern[0], din_pin);
      check("bit0_hi", pattern[0], din_pin_hi);
      for (int i = 1; i < 8; i++)
      begin
         i_scpr_loader.pulse(1);
         check("bit", pattern[i], din_pin);
         check("bit_hi", pattern[i], din_pin_hi);
      end
      check("cascade", 1'b1, cascade_select_out_n);
      check("cascade_hi", 1'b1, cascade_hi_n);
   endtask

   // standby freezes the address and floats the pin
   task automatic s_standby;
      i_scpr_loader.set_pins(1'b1, 1'b1);
      check("data_oe", 1'b0, data_oe);
      check("data_oe_hi", 1'b0, data_oe_hi);
      check("standby", 1'b1, standby_o);
      i_scpr_loader.pulse(2);
      i_scpr_loader.set_pins(1'b0, 1'b1);
      check("data_oe", 1'b1, data_oe);
      check("frozen", pattern[7], din_pin);
      check("frozen_hi", pattern[7], din_pin_hi);
   endtask

   // reset mid-stream returns to address zero
   task automatic s_reset;
      i_scpr_loader.set_pins(1'b0, 1'b0);
      check("data_oe", 1'b0, data_oe);
      check("data_oe_hi", 1'b0, data_oe_hi);
      check("din_float", 1'b1, din_pin);
      check("cascade", 1'b1, cascade_select_out_n);
      i_scpr_loader.set_pins(1'b0, 1'b1);
      check("bit0", pattern[0], din_pin);
      check("bit0_hi", pattern[0], din_pin_hi);
      i_scpr_loader.pulse(1);
      check("bit1", pattern[1], din_pin);
      check("bit1_hi", pattern[1], din_pin_hi);
   endtask

   // watchdog against a hang
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end

   // reset, program the store, run scenarios
   initial
   begin
      rst_n     = 1'b0;
      prog_we   = 1'b0;
      prog_addr = 16'h0000;
      prog_bit  = 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clock);
         prog_we   <= 1'b1;
         prog_addr <= 16'(i);
         prog_bit  <= pattern[i];
      end
      @(posedge clock);
      prog_we <= 1'b0;
      s_idle();
      s_read();
      s_standby();
      s_reset();
      summarize();
   end
endmodule
